// ### hdl/dqw_pkg.sv
package dqw_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_MASTER_CFG = 12'h800;
   localparam logic [11:0] OFS_DMA_STATUS = 12'h804;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h808;
   localparam logic [11:0] OFS_BASE_LOW   = 12'h830;
   localparam logic [11:0] OFS_BASE_HIGH  = 12'h834;
   localparam logic [11:0] OFS_END_OFFSET = 12'h838;
   localparam logic [11:0] OFS_HOST_RDPTR = 12'h83C;
   localparam logic [11:0] OFS_DMA_WRPTR  = 12'h840;
   localparam logic [11:0] OFS_FLUSH_TMR  = 12'h844;
   localparam logic [11:0] OFS_FIFO_CTRL  = 12'h880;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CFG_ACTIVATE_BIT = 0;
   localparam int CTRL_BURST_BIT   = 2;
   localparam int CTRL_FLUSH_BIT   = 3;
   localparam int CTRL_THR_LSB     = 8;
   localparam int STAT_WRITE_BIT   = 0;
   localparam int STAT_ERROR_BIT   = 1;
   localparam int DESC_CH_LSB      = 16;
   localparam int DESC_ST_LSB      = 26;

   // ---------------------------------------------------------------
   // Reset values, sizes and timing
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_REG16    = 16'h0000;
   localparam logic [15:0] RST_TIMER    = 16'h0000;
   localparam logic [3:0]  FIFO_DEPTH   = 4'h8;
   localparam logic [3:0]  HIGH_WATER   = 4'h6;
   localparam int          TICK_DIV     = 256;
   localparam logic [7:0]  PRESCALE_TOP = 8'(TICK_DIV - 1);
   localparam logic [15:0] CODE_MAX     = 16'hFFFF;
   localparam logic [16:0] COUNT_MAX    = 17'h10000;

   // Final status codes carried in a completion word
   localparam logic [2:0] ST_PACKET_DONE = 3'h0;
   localparam logic [2:0] ST_FIRST_BUF   = 3'h1;
   localparam logic [2:0] ST_MIDDLE_BUF  = 3'h2;
   localparam logic [2:0] ST_LAST_BUF    = 3'h3;
   localparam logic [2:0] ST_PROV_ERR    = 3'h4;
   localparam logic [2:0] ST_DESC_ERR    = 3'h5;
   localparam logic [2:0] ST_BUS_ERR     = 3'h6;
   localparam logic [2:0] ST_UNDERFLOW   = 3'h7;

   typedef enum logic [1:0] {DQW_IDLE, DQW_LOAD, DQW_WRITE, DQW_DROP}
      dqw_state_t;

   // Free slots in the circular queue, one slot kept unused
   function automatic logic [16:0] dqw_free_slots(
      input logic [15:0] wp, input logic [15:0] rp,
      input logic [15:0] endOfs);
      logic [16:0] len;
      logic [16:0] used;
      len  = {1'b0, endOfs} + 17'h00001;
      used = (wp >= rp) ? {1'b0, wp} - {1'b0, rp}
                        : {1'b0, wp} + len - {1'b0, rp};
      return len - 17'h00001 - used;
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] dqw_merge16(
      input logic [15:0] old, input logic [31:0] data,
      input logic [3:0] be);
      return {be[1] ? data[15:8] : old[15:8],
              be[0] ? data[7:0]  : old[7:0]};
   endfunction

endpackage

// ### hdl/dqw_desc_fifo.sv
`timescale 1ns/1ps

module dqw_desc_fifo
   import dqw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        inValid,
   output logic             inReady,
   input  wire logic [31:0] inData,
   output logic             outValid,
   input  wire logic        outReady,
   output logic [31:0]      outData,
   output logic [3:0]       count
);

   logic [31:0] mem [0:7];
   logic [2:0]  wrIdx;
   logic [2:0]  rdIdx;
   wire         doPush = inValid & inReady;
   wire         doPop  = outValid & outReady;

   // ----------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------
   assign inReady  = (count != FIFO_DEPTH);
   assign outValid = (count != 4'h0);
   assign outData  = mem[rdIdx];

   // Storage write
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrIdx] <= inData;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (srst) begin
         wrIdx <= 3'h0;
         rdIdx <= 3'h0;
         count <= 4'h0;
      end else begin
         if (doPush) wrIdx <= wrIdx + 3'h1;
         if (doPop)  rdIdx <= rdIdx + 3'h1;
         count <= count + 4'(doPush) - 4'(doPop);
      end
   end

endmodule // dqw_desc_fifo

// ### hdl/dqw_done_writer.sv
`timescale 1ns/1ps

module dqw_done_writer
   import dqw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [11:0] avAddress,
   input  wire logic        avRead,
   input  wire logic        avWrite,
   input  wire logic [31:0] avWriteData,
   input  wire logic [3:0]  avByteEnable,
   output logic [31:0]      avReadData,
   output logic             avWaitRequest,
   input  wire logic        descValid,
   output logic             descReady,
   input  wire logic [15:0] descOffset,
   input  wire logic [7:0]  descChannel,
   input  wire logic [2:0]  descStatus,
   output logic             memValid,
   input  wire logic        memReady,
   output logic [31:0]      memAddr,
   output logic [31:0]      memData,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [15:0] baseLow;
   logic [15:0] baseHigh;
   logic [15:0] endOfs;
   logic [15:0] rdPtr;
   logic [15:0] wrPtr;
   logic [15:0] timerReload;
   logic        burstEn;
   logic        flushBit;
   logic [2:0]  thr;
   logic        activate;
   logic [1:0]  irqEn;
   logic        statWrite;
   logic        statError;
   logic        busAck;

   // Engine state
   dqw_state_t  state;
   logic [3:0]  remaining;
   logic [7:0]  wrCount;
   logic [7:0]  prescale;
   logic [16:0] timerCnt;

   // FIFO side
   logic        fifoValid;
   logic [31:0] fifoData;
   logic [3:0]  fifoCount;
   logic        fifoPop;

   // ----------------------------------------------------------------
   // Bus decode: one wait state, answer on the second cycle
   // ----------------------------------------------------------------
   wire busReq   = avRead | avWrite;
   wire wrStrobe = avWrite & busAck;
   wire wrBase0  = wrStrobe & (avAddress == OFS_BASE_LOW);
   wire wrBase1  = wrStrobe & (avAddress == OFS_BASE_HIGH);
   wire wrEnd    = wrStrobe & (avAddress == OFS_END_OFFSET);
   wire wrRdPtr  = wrStrobe & (avAddress == OFS_HOST_RDPTR);
   wire wrWrPtr  = wrStrobe & (avAddress == OFS_DMA_WRPTR);
   wire wrTimer  = wrStrobe & (avAddress == OFS_FLUSH_TMR);
   wire wrCtrl   = wrStrobe & (avAddress == OFS_FIFO_CTRL)
                 & avByteEnable[0];
   wire wrThr    = wrStrobe & (avAddress == OFS_FIFO_CTRL)
                 & avByteEnable[1];
   wire wrCfg    = wrStrobe & (avAddress == OFS_MASTER_CFG)
                 & avByteEnable[0];
   wire wrIrqEn  = wrStrobe & (avAddress == OFS_IRQ_ENABLE)
                 & avByteEnable[0];
   wire wrStat   = wrStrobe & (avAddress == OFS_DMA_STATUS)
                 & avByteEnable[0];

   assign avWaitRequest = busReq & ~busAck;

   // Read data selection, unmapped reads return zero
   logic [15:0] ctrlWord;
   logic [15:0] rdMux;
   assign ctrlWord = {5'h00, thr, 4'h0, flushBit, burstEn, 2'h0};
   assign rdMux =
      (avAddress == OFS_BASE_LOW)   ? baseLow :
      (avAddress == OFS_BASE_HIGH)  ? baseHigh :
      (avAddress == OFS_END_OFFSET) ? endOfs :
      (avAddress == OFS_HOST_RDPTR) ? rdPtr :
      (avAddress == OFS_DMA_WRPTR)  ? wrPtr :
      (avAddress == OFS_FLUSH_TMR)  ? timerReload :
      (avAddress == OFS_FIFO_CTRL)  ? ctrlWord :
      (avAddress == OFS_MASTER_CFG) ? {15'h0000, activate} :
      (avAddress == OFS_IRQ_ENABLE) ? {14'h0000, irqEn} :
      (avAddress == OFS_DMA_STATUS) ? {14'h0000, statError, statWrite} :
      16'h0000;

   // Bus answer and read capture
   always_ff @(posedge clk) begin
      if (srst) begin
         busAck     <= 1'b0;
         avReadData <= 32'h0000_0000;
      end else begin
         busAck <= busReq & ~busAck;
         if (avRead & ~busAck) avReadData <= {16'h0000, rdMux};
      end
   end

   // ----------------------------------------------------------------
   // Host-programmed registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         baseLow     <= RST_REG16;
         baseHigh    <= RST_REG16;
         endOfs      <= RST_REG16;
         rdPtr       <= RST_REG16;
         timerReload <= RST_TIMER;
         burstEn     <= 1'b0;
         flushBit    <= 1'b0;
         thr         <= 3'h0;
         activate    <= 1'b0;
         irqEn       <= 2'h0;
      end else begin
         if (wrBase0) baseLow <= dqw_merge16(baseLow, avWriteData,
                                             avByteEnable);
         if (wrBase1) baseHigh <= dqw_merge16(baseHigh, avWriteData,
                                              avByteEnable);
         if (wrEnd) endOfs <= dqw_merge16(endOfs, avWriteData,
                                          avByteEnable);
         // Only the host moves the read pointer
         if (wrRdPtr) rdPtr <= dqw_merge16(rdPtr, avWriteData,
                                           avByteEnable);
         if (wrTimer) timerReload <= dqw_merge16(timerReload,
                                                 avWriteData,
                                                 avByteEnable);
         if (wrCtrl) begin
            burstEn  <= avWriteData[CTRL_BURST_BIT];
            flushBit <= avWriteData[CTRL_FLUSH_BIT];
         end
         if (wrThr) thr <= avWriteData[CTRL_THR_LSB +: 3];
         if (wrCfg) activate <= avWriteData[CFG_ACTIVATE_BIT];
         if (wrIrqEn) irqEn <= avWriteData[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Descriptor FIFO
   // ----------------------------------------------------------------
   logic [31:0] descWord;
   assign descWord = {3'h0, descStatus, 2'h0, descChannel,
                      descOffset};

   dqw_desc_fifo u_fifo (
      .clk      (clk),
      .srst     (srst),
      .inValid  (descValid),
      .inReady  (descReady),
      .inData   (descWord),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData),
      .count    (fifoCount)
   );

   // ----------------------------------------------------------------
   // Write decision
   // ----------------------------------------------------------------
   logic [16:0] room;
   logic [3:0]  want;
   logic [3:0]  grant;
   logic        timerExpired;
   logic        trigger;
   logic        accept;
   logic [31:0] targetAddr;
   logic [15:0] nextWrPtr;

   assign room = dqw_free_slots(wrPtr, rdPtr, endOfs);
   assign timerExpired = burstEn & (timerCnt == 17'h00000);
   assign trigger = activate & fifoValid
                  & (~burstEn | (fifoCount >= HIGH_WATER)
                     | flushBit | timerExpired);
   assign want  = burstEn ? fifoCount : 4'h1;
   assign grant = (room < {13'h0000, want}) ? room[3:0] : want;
   assign accept = memValid & memReady;
   assign targetAddr = {baseHigh, baseLow}
                     + {14'h0000, wrPtr, 2'b00};
   // Wrap when the advanced pointer passes the relative end
   assign nextWrPtr = (wrPtr >= endOfs) ? 16'h0000
                                        : wrPtr + 16'h0001;
   assign fifoPop = accept | (state == DQW_DROP);
   assign memValid = (state == DQW_WRITE);

   // Sequencer: plan, load one word, write it, repeat
   always_ff @(posedge clk) begin
      if (srst) begin
         state     <= DQW_IDLE;
         remaining <= 4'h0;
         memAddr   <= 32'h0000_0000;
         memData   <= 32'h0000_0000;
      end else begin
         case (state)
            DQW_IDLE: begin
               if (trigger) begin
                  if (room == 17'h00000) begin
                     remaining <= want;
                     state     <= DQW_DROP;
                  end else begin
                     remaining <= grant;
                     state     <= DQW_LOAD;
                  end
               end
            end
            DQW_LOAD: begin
               memAddr <= targetAddr;
               memData <= fifoData;
               state   <= DQW_WRITE;
            end
            DQW_WRITE: begin
               if (accept) begin
                  remaining <= remaining - 4'h1;
                  state <= (remaining == 4'h1) ? DQW_IDLE : DQW_LOAD;
               end
            end
            DQW_DROP: begin
               remaining <= remaining - 4'h1;
               if (remaining == 4'h1) state <= DQW_IDLE;
            end
            default: state <= DQW_IDLE;
         endcase
      end
   end

   // Device-owned write pointer; host may seed it while inactive
   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr <= RST_REG16;
      end else if (accept) begin
         wrPtr <= nextWrPtr;
      end else if (wrWrPtr & ~activate) begin
         wrPtr <= dqw_merge16(wrPtr, avWriteData, avByteEnable);
      end
   end

   // ----------------------------------------------------------------
   // Flush timer: 256-clock prescale, 16-bit reload
   // ----------------------------------------------------------------
   logic        tick;
   logic [16:0] reloadCount;
   assign tick = (prescale == PRESCALE_TOP);
   assign reloadCount = (timerReload == CODE_MAX) ? COUNT_MAX
                                                  : {1'b0, timerReload};

   always_ff @(posedge clk) begin
      if (srst) begin
         prescale <= 8'h00;
         timerCnt <= {1'b0, RST_TIMER};
      end else begin
         prescale <= prescale + 8'h01;
         if (accept | ~fifoValid | ~burstEn) begin
            timerCnt <= reloadCount;
         end else if (tick & (timerCnt != 17'h00000)) begin
            timerCnt <= timerCnt - 17'h00001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status flags: set beats clear, write one to clear
   // ----------------------------------------------------------------
   logic [8:0] nextCount;
   logic [8:0] thrTarget;
   logic       thrHit;
   logic       setError;
   assign nextCount = {1'b0, wrCount} + 9'h001;
   assign thrTarget = 9'h001 << thr;
   assign thrHit    = accept & (nextCount >= thrTarget);
   assign setError  = (state == DQW_IDLE) & trigger
                    & (room == 17'h00000);

   always_ff @(posedge clk) begin
      if (srst) begin
         wrCount   <= 8'h00;
         statWrite <= 1'b0;
         statError <= 1'b0;
      end else begin
         if (thrHit) wrCount <= 8'h00;
         else if (accept) wrCount <= nextCount[7:0];
         statWrite <= (statWrite & ~(wrStat & avWriteData[STAT_WRITE_BIT]))
                    | thrHit;
         statError <= (statError & ~(wrStat & avWriteData[STAT_ERROR_BIT]))
                    | setError;
      end
   end

   assign irq = (statWrite & irqEn[0]) | (statError & irqEn[1]);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_active_only;
      @(posedge clk) disable iff (srst) memValid |-> activate;
   endproperty
   a_active_only: assert property (p_active_only)
      else $error("queue write while inactive");

   property p_target;
      @(posedge clk) disable iff (srst)
         memValid |-> memAddr == {baseHigh, baseLow}
                                 + {14'h0000, wrPtr, 2'b00};
   endproperty
   a_target: assert property (p_target)
      else $error("queue address not base plus pointer");

   property p_wrap;
      @(posedge clk) disable iff (srst)
         accept && wrPtr >= endOfs |=> wrPtr == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("write pointer did not wrap");

   property p_step;
      @(posedge clk) disable iff (srst)
         accept && wrPtr < endOfs |=> wrPtr == $past(wrPtr) + 16'h0001;
   endproperty
   a_step: assert property (p_step)
      else $error("write pointer did not step by one");

   property p_no_room;
      @(posedge clk) disable iff (srst)
         setError |=> statError ##1 !memValid [*2];
   endproperty
   a_no_room: assert property (p_no_room)
      else $error("overflow not flagged or write issued");

   property p_room_kept;
      @(posedge clk) disable iff (srst)
         memValid |-> room != 17'h00000;
   endproperty
   a_room_kept: assert property (p_room_kept)
      else $error("write into full queue");

   property p_thr_every;
      @(posedge clk) disable iff (srst)
         accept && thr == 3'h0 |=> statWrite;
   endproperty
   a_thr_every: assert property (p_thr_every)
      else $error("write flag missing at threshold zero");

   property p_hold_low;
      @(posedge clk) disable iff (srst)
         state == DQW_IDLE && burstEn && !flushBit && !timerExpired
         && fifoCount < HIGH_WATER |=> state != DQW_LOAD;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("burst started below high water");

   property p_reload;
      @(posedge clk) disable iff (srst)
         accept |=> timerCnt == $past(reloadCount);
   endproperty
   a_reload: assert property (p_reload)
      else $error("timer not reloaded on write");

   property p_single;
      @(posedge clk) disable iff (srst)
         !burstEn && state == DQW_IDLE && trigger && room != 17'h00000
         |=> remaining == 4'h1;
   endproperty
   a_single: assert property (p_single)
      else $error("unbuffered mode wrote more than one");

   c_burst: cover property (@(posedge clk) disable iff (srst)
      state == DQW_IDLE && trigger && burstEn && grant == HIGH_WATER);
   c_expire: cover property (@(posedge clk) disable iff (srst)
      state == DQW_IDLE && trigger && timerExpired);
   c_wrap: cover property (@(posedge clk) disable iff (srst)
      accept && wrPtr >= endOfs);
   c_error: cover property (@(posedge clk) disable iff (srst) setError);

endmodule // dqw_done_writer

// ### tb/dqw_host_mem.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Host memory end of the completion queue
// ------------------------------------------------
module dqw_host_mem (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        slow,
   input  wire logic        memValid,
   output logic             memReady,
   input  wire logic [31:0] memAddr,
   input  wire logic [31:0] memData,
   output logic [15:0]      wrCount,
   output logic [31:0]      lastAddr,
   output logic [31:0]      lastData
);
   logic phase;
   // Ready every cycle, or every other cycle when slow
   assign memReady = !slow || phase;
   // Count each accepted completion word and keep the last one
   always_ff @(posedge clk) begin
      if (srst) begin
         phase   <= 1'b0;
         wrCount <= 16'h0000;
      end else begin
         phase <= ~phase;
         if (memValid && memReady) begin
            wrCount  <= wrCount + 16'h0001;
            lastAddr <= memAddr;
            lastData <= memData;
         end
      end
   end
endmodule // dqw_host_mem

// ### tb/tx_done_queue_writer_test.sv
`timescale 1ns/1ps
module tx_done_queue_writer_test import dqw_pkg::*;;
   typedef struct {logic [15:0] o; logic [7:0] c; logic [2:0] s;
      logic [31:0] a;} dqw_row_t;
   logic        clk, srst, avRead, avWrite, descValid, slow;
   logic [11:0] avAddress;
   logic [31:0] avWriteData, d;
   logic [15:0] descOffset;
   logic [7:0]  descChannel;
   logic [2:0]  descStatus;
   wire         avWaitRequest, descReady, memValid, memReady, irq;
   wire [31:0]  avReadData, memAddr, memData, lastAddr, lastData;
   wire [15:0]  wrCount;
   int          errors, testsRun, i;
   dqw_row_t    rows [8] = '{
      '{16'h0000, 8'h00, 3'h0, 32'h00021000},
      '{16'hFFFF, 8'hFF, 3'h1, 32'h00021004},
      '{16'h1234, 8'h01, 3'h2, 32'h00021008},
      '{16'h8001, 8'h80, 3'h3, 32'h0002100C},
      '{16'h0042, 8'h7F, 3'h4, 32'h00021000},
      '{16'hA5A5, 8'h5A, 3'h5, 32'h00021004},
      '{16'h00FF, 8'h10, 3'h6, 32'h00021008},
      '{16'h7FFE, 8'hFE, 3'h7, 32'h0002100C}};
   // ------------------------------------------------
   // Design, host memory, clock and bus tasks
   // ------------------------------------------------
   dqw_done_writer dut (.clk, .srst, .avAddress, .avRead, .avWrite,
      .avWriteData, .avByteEnable(4'hF), .avReadData, .avWaitRequest,
      .descValid, .descReady, .descOffset, .descChannel, .descStatus,
      .memValid, .memReady, .memAddr, .memData, .irq);
   dqw_host_mem host (.clk, .srst, .slow, .memValid, .memReady,
      .memAddr, .memData, .wrCount, .lastAddr, .lastData);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] v, output logic [31:0] r);
      @(posedge clk);
      avAddress   <= a;
      avWriteData <= v;
      avWrite     <= w;
      avRead      <= !w;
      // Only the watchdog ends a wait that never sees the answer
      do begin
         @(posedge clk);
      end while (avWaitRequest !== 1'b0);
      r = avReadData;
      avWrite <= 1'b0;
      avRead  <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] x;
      bus(1'b1, a, v, x);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, exp);
   endtask
   task automatic send(input int k);
      @(posedge clk);
      descValid   <= 1'b1;
      descOffset  <= rows[k].o;
      descChannel <= rows[k].c;
      descStatus  <= rows[k].s;
      do begin
         @(posedge clk);
      end while (descReady !== 1'b1);
      descValid <= 1'b0;
   endtask
   task automatic wait_wr(input logic [15:0] n, input int lim);
      int k;
      for (k = 0; k < lim && wrCount < n; k++) @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("errors %0d testsRun %0d", errors, testsRun);
      if (errors == 0 && testsRun > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Watchdog on a hung run
   initial begin
      #480000;
      errors++;
      wrap_up();
   end
   // Main sequence
   initial begin
      {srst, avRead, avWrite, descValid, slow} = 5'h10;
      {avAddress, avWriteData, descOffset, descChannel} = 68'h0;
      descStatus = 3'h0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      rdc(OFS_FLUSH_TMR, 32'h0);
      rdc(OFS_FIFO_CTRL, 32'h0);
      wr(12'h900, 32'h0000FFFF);
      rdc(12'h900, 32'h0);
      wr(OFS_BASE_LOW, 32'h1000);
      wr(OFS_BASE_HIGH, 32'h0002);
      wr(OFS_END_OFFSET, 32'h0003);
      wr(OFS_IRQ_ENABLE, 32'h0003);
      for (i = 0; i < 8; i++) begin
         slow <= i[0];
         send(i);
         if (i == 0) begin
            repeat (20) @(posedge clk);
            chk(wrCount, 32'h0);
            wr(OFS_MASTER_CFG, 32'h1);
         end
         wait_wr(i + 1, 100);
         chk(lastAddr, rows[i].a);
         chk(lastData, {3'h0, rows[i].s, 2'h0, rows[i].c, rows[i].o});
         rdc(OFS_DMA_STATUS, 32'h1);
         wr(OFS_DMA_STATUS, 32'h1);
         bus(1'b0, OFS_DMA_WRPTR, 32'h0, d);
         wr(OFS_HOST_RDPTR, d);
      end
      // Full queue refuses the fourth word
      for (i = 0; i < 4; i++) send(i);
      repeat (30) @(posedge clk);
      chk(wrCount, 32'd11);
      rdc(OFS_DMA_WRPTR, 32'h3);
      wr(OFS_DMA_WRPTR, 32'h1);
      rdc(OFS_DMA_WRPTR, 32'h3);
      rdc(OFS_DMA_STATUS, 32'h3);
      chk(irq, 1'b1);
      wr(OFS_IRQ_ENABLE, 32'h0);
      @(negedge clk);
      chk(irq, 1'b0);
      wr(OFS_DMA_STATUS, 32'h3);
      // Burst mode with high-water mark, flush and timer
      wr(OFS_MASTER_CFG, 32'h0);
      wr(OFS_DMA_WRPTR, 32'h0);
      wr(OFS_HOST_RDPTR, 32'h0);
      wr(OFS_END_OFFSET, 32'h00FF);
      wr(OFS_FLUSH_TMR, 32'hFFFF);
      wr(OFS_FIFO_CTRL, 32'h0104);
      wr(OFS_MASTER_CFG, 32'h1);
      for (i = 0; i < 5; i++) send(i);
      repeat (30) @(posedge clk);
      chk(wrCount, 32'd11);
      send(5);
      wait_wr(17, 100);
      chk(lastAddr, 32'h00021014);
      rdc(OFS_DMA_WRPTR, 32'h6);
      rdc(OFS_DMA_STATUS, 32'h1);
      wr(OFS_FLUSH_TMR, 32'h0002);
      send(6);
      send(7);
      repeat (30) @(posedge clk);
      chk(wrCount, 32'd17);
      wr(OFS_FIFO_CTRL, 32'h010C);
      wait_wr(19, 100);
      wr(OFS_FIFO_CTRL, 32'h0104);
      chk(wrCount, 32'd19);
      send(0);
      repeat (200) @(posedge clk);
      chk(wrCount, 32'd19);
      wait_wr(20, 900);
      chk(wrCount, 32'd20);
      // Mid-run reset returns the registers to zero
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rdc(OFS_FLUSH_TMR, 32'h0);
      rdc(OFS_DMA_WRPTR, 32'h0);
      rdc(OFS_FIFO_CTRL, 32'h0);
      rdc(OFS_DMA_STATUS, 32'h0);
      chk(irq, 1'b0);
      wrap_up();
   end
endmodule // tx_done_queue_writer_test
